//--- tpm_bus_model.sv
// Model of the traced processor bus and the external probe.
// Assumes the bench gives the bus fields and the probe state each cycle.
// ****
// Bus and probe model
// ****
module tpm_bus_model (
    // Processor bus fields
    input wire logic [23:0] addr,
    input wire logic [7:0] stat,
    input wire logic [15:0] data,
    // External probe
    input wire logic [15:0] xb,
    input wire logic aligned,
    // Captured state
    output logic [47:0] trace_state,
    output logic [15:0] xbit_state
);
    // Trace signals laid out as the captured state word
    assign trace_state = {data, stat, addr};
    // A probe that is not aligned shows its bits inverted, never the true value
    assign xbit_state = aligned ? xb : ~xb;
endmodule : tpm_bus_model

//--- tpm_cfg.svh
// Constants for the trace pattern matcher: field positions and qualifier codes.
// Assumes inclusion by the package and the matcher module only.
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH
// Captured state field positions
`define TPM_ADDR_LO 0
`define TPM_ADDR_HI 23
`define TPM_STAT_LO 24
`define TPM_STAT_HI 31
`define TPM_DATA_LO 32
`define TPM_DATA_HI 47
// Status qualifier codes: value and care mask, bit 0 is status bit 24
`define TPM_QUAL_BYTE_VAL 8'h01
`define TPM_QUAL_BYTE_MSK 8'h01
`define TPM_QUAL_WORD_VAL 8'h00
`define TPM_QUAL_WORD_MSK 8'h01
`define TPM_QUAL_WRITE_VAL 8'h00
`define TPM_QUAL_WRITE_MSK 8'h02
`endif

//--- tpm_matcher.sv
// Trace pattern matcher: compares each captured bus state with patterns and a range.
// Assumes configuration inputs are held stable by the sequencer while tracing.
//
// Summary of operation
// - Each pattern selects equal or not-equal sense
// - Per-label comparisons are ANDed together
// - Address label is trace bits 0 to 23
// - Data label is trace bits 32 to 47
// - Status label is trace bits 24 to 31
// - External bits compared only when probe aligned, else ignored by patterns and never hit by the range
// - Range checks one label between two bounds
// - Byte, word, write status qualifiers built in
// - Qualifiers usable as any pattern's status value
// - User label compares a chosen trace bit group
// - Per-bit masks; all don't-care matches always with equal sense, never with not-equal sense
`include "tpm_cfg.svh"
module tpm_matcher #(
    parameter int NUM_PAT = 4,
    parameter int XBIT_W = 16
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    // Captured state
    input wire logic sample_vld,
    input wire logic [47:0] trace_state,
    input wire logic [XBIT_W-1:0] xbit_state,
    input wire logic xprobe_aligned,
    // Resource configuration
    input wire tpm_pkg::tpm_pat_s [NUM_PAT-1:0] pat_cfg,
    input wire tpm_pkg::tpm_rng_s rng_cfg,
    // Match flags
    output logic [NUM_PAT-1:0] pat_hit_ff,
    output logic rng_hit_ff,
    output logic hit_vld_ff
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    // Refused at elaboration: the flag vector and the probe cast serve no other sizes
    if (NUM_PAT < 1 || NUM_PAT > 8) begin : g_bad_num_pat
        $error("NUM_PAT must be 1 to 8");
    end
    if (XBIT_W < 1 || XBIT_W > 16) begin : g_bad_xbit_w
        $error("XBIT_W must be 1 to 16");
    end

    // ****************************************
    // Comparison
    // ****************************************
    // Masked compare: a zero mask bit is don't-care
    function automatic logic masked_eq(input logic [47:0] a, input logic [47:0] v,
                                       input logic [47:0] m);
        masked_eq = ((a ^ v) & m) == 48'h0;
    endfunction : masked_eq

    logic [23:0] addr_f;
    logic [15:0] data_f;
    logic [7:0] stat_f;
    logic [15:0] xbit_f;
    assign addr_f = trace_state[`TPM_ADDR_HI:`TPM_ADDR_LO];
    assign data_f = trace_state[`TPM_DATA_HI:`TPM_DATA_LO];
    assign stat_f = trace_state[`TPM_STAT_HI:`TPM_STAT_LO];
    assign xbit_f = 16'(xbit_state);

    logic [NUM_PAT-1:0] nxt_pat_hit;
    logic nxt_rng_hit;

    // Per-pattern evaluation; qualifiers replace the user status value
    always_comb begin
        logic [7:0] sv;
        logic [7:0] sm;
        logic all_eq;
        sv = 8'h00;
        sm = 8'h00;
        all_eq = 1'b0;
        for (int i = 0; i < NUM_PAT; i++) begin
            case (pat_cfg[i].stat_qual)
                tpm_pkg::TPM_QUAL_BYTE: begin
                    sv = `TPM_QUAL_BYTE_VAL;
                    sm = `TPM_QUAL_BYTE_MSK;
                end
                tpm_pkg::TPM_QUAL_WORD: begin
                    sv = `TPM_QUAL_WORD_VAL;
                    sm = `TPM_QUAL_WORD_MSK;
                end
                tpm_pkg::TPM_QUAL_WRITE: begin
                    sv = `TPM_QUAL_WRITE_VAL;
                    sm = `TPM_QUAL_WRITE_MSK;
                end
                default: begin
                    sv = pat_cfg[i].stat_val;
                    sm = pat_cfg[i].stat_msk;
                end
            endcase
            all_eq = masked_eq({24'h0, addr_f}, {24'h0, pat_cfg[i].addr_val},
                               {24'h0, pat_cfg[i].addr_msk})
                   & masked_eq({32'h0, data_f}, {32'h0, pat_cfg[i].data_val},
                               {32'h0, pat_cfg[i].data_msk})
                   & masked_eq({40'h0, stat_f}, {40'h0, sv}, {40'h0, sm})
                   & masked_eq(trace_state, pat_cfg[i].user_val, pat_cfg[i].user_msk)
                   & (!xprobe_aligned |
                      masked_eq({32'h0, xbit_f}, {32'h0, pat_cfg[i].xbit_val},
                                {32'h0, pat_cfg[i].xbit_msk}));
            nxt_pat_hit[i] = all_eq ^ pat_cfg[i].not_eq_sel;
        end
    end

    // Range check on the selected label, bounds inclusive
    always_comb begin
        logic [23:0] v;
        v = 24'h0;
        case (rng_cfg.label)
            tpm_pkg::TPM_LBL_ADDR: v = addr_f;
            tpm_pkg::TPM_LBL_DATA: v = {8'h00, data_f};
            tpm_pkg::TPM_LBL_STAT: v = {16'h0000, stat_f};
            tpm_pkg::TPM_LBL_XBIT: v = {8'h00, xbit_f};
            default: v = addr_f;
        endcase
        // Without an aligned probe the external label never hits
        nxt_rng_hit = (v >= rng_cfg.lo_bound) && (v <= rng_cfg.hi_bound)
                    && (rng_cfg.label != tpm_pkg::TPM_LBL_XBIT || xprobe_aligned);
    end

    // ****************************************
    // Output registers
    // ****************************************
    // Flags are held between samples so the sequencer sees a stable level
    always_ff @(posedge clk) begin
        if (srst) begin
            pat_hit_ff <= '0;
            rng_hit_ff <= 1'b0;
        end else if (clk_en && sample_vld) begin
            pat_hit_ff <= nxt_pat_hit;
            rng_hit_ff <= nxt_rng_hit;
        end
    end

    // Valid strobe, one cycle after a sample
    always_ff @(posedge clk) begin
        if (srst) begin
            hit_vld_ff <= 1'b0;
        end else if (clk_en) begin
            hit_vld_ff <= sample_vld;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_flag_lat;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld) |=> (pat_hit_ff == $past(nxt_pat_hit) && hit_vld_ff);
    endproperty
    a_flag_lat: assert property (p_flag_lat) else $error("pattern flags late");

    property p_rng_lat;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld) |=> rng_hit_ff == $past(nxt_rng_hit);
    endproperty
    a_rng_lat: assert property (p_rng_lat) else $error("range flag late");

    property p_vld_drop;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && !sample_vld) |=> !hit_vld_ff;
    endproperty
    a_vld_drop: assert property (p_vld_drop) else $error("valid without sample");

    property p_hold;
        @(posedge clk) disable iff (srst)
        (!srst && !(clk_en && sample_vld)) |=> $stable(pat_hit_ff) && $stable(rng_hit_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("flags changed without sample");

    property p_xrng;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld && !xprobe_aligned
         && rng_cfg.label == tpm_pkg::TPM_LBL_XBIT)
        |=> !rng_hit_ff;
    endproperty
    a_xrng: assert property (p_xrng) else $error("xbit range without probe");

    property p_rng_out;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld && rng_cfg.label == tpm_pkg::TPM_LBL_ADDR
         && addr_f > rng_cfg.hi_bound) |=> !rng_hit_ff;
    endproperty
    a_rng_out: assert property (p_rng_out) else $error("range hit above bound");

    property p_rng_in;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld && rng_cfg.label == tpm_pkg::TPM_LBL_ADDR
         && addr_f >= rng_cfg.lo_bound && addr_f <= rng_cfg.hi_bound) |=> rng_hit_ff;
    endproperty
    a_rng_in: assert property (p_rng_in) else $error("range miss inside bounds");

    property p_dontcare;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld && pat_cfg[0].addr_msk == 24'h0
         && pat_cfg[0].data_msk == 16'h0
         && pat_cfg[0].stat_qual == tpm_pkg::TPM_QUAL_USER && pat_cfg[0].stat_msk == 8'h0
         && pat_cfg[0].user_msk == 48'h0 && !xprobe_aligned)
        |=> pat_hit_ff[0] == !$past(pat_cfg[0].not_eq_sel);
    endproperty
    a_dontcare: assert property (p_dontcare) else $error("all don't-care mismatch");

    property p_byte;
        @(posedge clk) disable iff (srst)
        (!srst && clk_en && sample_vld && pat_cfg[0].stat_qual == tpm_pkg::TPM_QUAL_BYTE
         && !pat_cfg[0].not_eq_sel && !stat_f[0]) |=> !pat_hit_ff[0];
    endproperty
    a_byte: assert property (p_byte) else $error("byte qualifier matched word");

    // Reset clears every flag on the next edge, whatever the enable does
    property p_reset;
        @(posedge clk)
        srst |=> (pat_hit_ff == '0 && !rng_hit_ff && !hit_vld_ff);
    endproperty
    a_reset: assert property (p_reset) else $error("flags not cleared by reset");

    // A low enable freezes the valid strobe as well as the flags
    property p_freeze;
        @(posedge clk) disable iff (srst)
        (!srst && !clk_en) |=> $stable(hit_vld_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("valid moved while disabled");
endmodule : tpm_matcher

//--- tpm_matcher_tb.sv
// Self-checking bench for the trace pattern matcher.
// Assumes tpm_pkg and tpm_bus_model are compiled first.
// ****
// Bench
// ****
module tpm_matcher_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [23:0] a; logic [7:0] s; logic [15:0] d; logic [15:0] x; logic al;
        logic [3:0] ep; logic er;
    } tpm_row_s;
    logic clk = 1'b0, srst = 1'b1, clk_en = 1'b1, sample_vld = 1'b0, al = 1'b0;
    logic [23:0] a = 24'h0;
    logic [7:0] s = 8'h0;
    logic [15:0] d = 16'h0, x = 16'h0;
    logic [47:0] trace_state;
    logic [15:0] xbit_state;
    tpm_pkg::tpm_pat_s [3:0] pat_cfg = '0;
    tpm_pkg::tpm_rng_s rng_cfg = '0;
    logic [3:0] pat_hit_ff;
    logic rng_hit_ff, hit_vld_ff;
    int miscompares = 0, check_count = 0;
    // Pattern 0 equal, 1 not equal, 2 byte qualifier, 3 probe bits
    tpm_row_s rows [6] = '{
        {24'h000500, 8'h01, 16'h1234, 16'h00AB, 1'b1, 4'hD, 1'b0},
        {24'h000500, 8'h00, 16'h1235, 16'h0000, 1'b1, 4'h2, 1'b0},
        {24'h0001FF, 8'hFF, 16'h0000, 16'h0000, 1'b0, 4'hE, 1'b1},
        {24'h000100, 8'h02, 16'h1234, 16'h0000, 1'b0, 4'hA, 1'b1},
        {24'h0000FF, 8'h01, 16'h1234, 16'h00AB, 1'b1, 4'hE, 1'b0},
        {24'h000200, 8'h00, 16'h0000, 16'h00AC, 1'b1, 4'h2, 1'b0}};
    logic [3:0] qexp = 4'b0101;
    initial forever #25 clk = ~clk;
    tpm_bus_model u_bus (.addr(a), .stat(s), .data(d), .xb(x), .aligned(al),
        .trace_state(trace_state), .xbit_state(xbit_state));
    tpm_matcher u_dut (.clk(clk), .srst(srst), .clk_en(clk_en), .sample_vld(sample_vld),
        .trace_state(trace_state), .xbit_state(xbit_state), .xprobe_aligned(al),
        .pat_cfg(pat_cfg), .rng_cfg(rng_cfg), .pat_hit_ff(pat_hit_ff),
        .rng_hit_ff(rng_hit_ff), .hit_vld_ff(hit_vld_ff));
    // Compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One sample, checked one cycle after it is taken
    task smp(input logic [23:0] ai, input logic [7:0] si, input logic [15:0] di,
             input logic [15:0] xi, input logic ali);
        @(posedge clk);
        a <= ai; s <= si; d <= di; x <= xi; al <= ali; sample_vld <= 1'b1;
        @(posedge clk);
        #1;
    endtask : smp
    task end_of_test;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Hang guard at 4000 cycles, well past the 60 or so cycles of the tests
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial begin
        pat_cfg[0].addr_val = 24'h000500;
        pat_cfg[0].addr_msk = 24'hFFFFFF;
        pat_cfg[0].data_val = 16'h1234;
        pat_cfg[0].data_msk = 16'hFFFF;
        pat_cfg[1] = pat_cfg[0];
        pat_cfg[1].not_eq_sel = 1'b1;
        pat_cfg[2].stat_qual = tpm_pkg::TPM_QUAL_BYTE;
        pat_cfg[3].xbit_val = 16'h00AB;
        pat_cfg[3].xbit_msk = 16'h00FF;
        rng_cfg.label = tpm_pkg::TPM_LBL_ADDR;
        rng_cfg.lo_bound = 24'h000100;
        rng_cfg.hi_bound = 24'h0001FF;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk({2'h0, pat_hit_ff, rng_hit_ff, hit_vld_ff}, 8'h00);
        // Ordinary cases
        foreach (rows[i]) begin
            smp(rows[i].a, rows[i].s, rows[i].d, rows[i].x, rows[i].al);
            chk({4'h0, pat_hit_ff}, {4'h0, rows[i].ep});
            chk({7'h0, rng_hit_ff}, {7'h0, rows[i].er});
            chk({7'h0, hit_vld_ff}, 8'h01);
        end
        // Flags stand while no sample is taken
        @(posedge clk) sample_vld <= 1'b0;
        a <= 24'h000500;
        d <= 16'h1234;
        @(posedge clk);
        #1;
        chk({7'h0, hit_vld_ff}, 8'h00);
        chk({4'h0, pat_hit_ff}, 8'h02);
        // Every status qualifier as the status value of one pattern
        @(posedge clk) pat_cfg[2].stat_val <= 8'h02;
        pat_cfg[2].stat_msk <= 8'hFF;
        for (int q = 0; q < 4; q++) begin
            @(posedge clk) pat_cfg[2].stat_qual <= tpm_pkg::tpm_qual_e'(q);
            smp(24'h0, 8'h02, 16'h0, 16'h0, 1'b0);
            chk({7'h0, pat_hit_ff[2]}, {7'h0, qexp[q]});
        end
        // Range on the data label
        @(posedge clk) rng_cfg.label <= tpm_pkg::TPM_LBL_DATA;
        rng_cfg.lo_bound <= 24'h001234;
        rng_cfg.hi_bound <= 24'h001234;
        smp(24'h0, 8'h0, 16'h1234, 16'h0, 1'b0);
        chk({7'h0, rng_hit_ff}, 8'h01);
        // All don't-care pattern matches anything, then the byte qualifier alone
        @(posedge clk) pat_cfg[0].addr_msk <= 24'h0;
        pat_cfg[0].data_msk <= 16'h0;
        smp(24'hABCDEF, 8'h02, 16'h5A5A, 16'h0, 1'b0);
        chk({7'h0, pat_hit_ff[0]}, 8'h01);
        @(posedge clk) pat_cfg[0].stat_qual <= tpm_pkg::TPM_QUAL_BYTE;
        smp(24'hABCDEF, 8'h02, 16'h5A5A, 16'h0, 1'b0);
        chk({7'h0, pat_hit_ff[0]}, 8'h00);
        // User label on the high data byte, ANDed with the byte qualifier
        @(posedge clk) pat_cfg[0].user_val <= 48'h5A0000000000;
        pat_cfg[0].user_msk <= 48'hFF0000000000;
        smp(24'hABCDEF, 8'h01, 16'h5A00, 16'h0, 1'b0);
        chk({7'h0, pat_hit_ff[0]}, 8'h01);
        smp(24'hABCDEF, 8'h01, 16'h1200, 16'h0, 1'b0);
        chk({7'h0, pat_hit_ff[0]}, 8'h00);
        // Range on probe bits hits only with the probe aligned
        @(posedge clk) rng_cfg.label <= tpm_pkg::TPM_LBL_XBIT;
        rng_cfg.lo_bound <= 24'h000000;
        rng_cfg.hi_bound <= 24'h00FFFF;
        smp(24'h0, 8'h0, 16'h0, 16'h00AB, 1'b0);
        chk({7'h0, rng_hit_ff}, 8'h00);
        smp(24'h0, 8'h0, 16'h0, 16'h00AB, 1'b1);
        chk({7'h0, rng_hit_ff}, 8'h01);
        // Enable low freezes flags and valid although a sample is offered
        @(posedge clk) clk_en <= 1'b0;
        al <= 1'b0;
        @(posedge clk);
        #1;
        chk({2'h0, pat_hit_ff, rng_hit_ff, hit_vld_ff}, 8'h3B);
        @(posedge clk) clk_en <= 1'b1;
        @(posedge clk);
        #1;
        chk({7'h0, rng_hit_ff}, 8'h00);
        // Reset in mid-run clears the flags, and sampling resumes after release
        @(posedge clk) srst <= 1'b1;
        @(posedge clk);
        #1;
        chk({2'h0, pat_hit_ff, rng_hit_ff, hit_vld_ff}, 8'h00);
        @(posedge clk) srst <= 1'b0;
        smp(24'h000500, 8'h01, 16'h1234, 16'h0, 1'b0);
        chk({2'h0, pat_hit_ff, rng_hit_ff, hit_vld_ff}, 8'h31);
        end_of_test();
    end
endmodule : tpm_matcher_tb

//--- tpm_pkg.sv
// Types for the trace pattern matcher.
// Assumes tpm_cfg.svh is on the include path.
`include "tpm_cfg.svh"
package tpm_pkg;
    // Status qualifier selection for a pattern's status field
    typedef enum logic [1:0] {
        TPM_QUAL_USER = 2'h0,
        TPM_QUAL_BYTE = 2'h1,
        TPM_QUAL_WORD = 2'h2,
        TPM_QUAL_WRITE = 2'h3
    } tpm_qual_e;
    // Label selectors for the range resource
    typedef enum logic [1:0] {
        TPM_LBL_ADDR = 2'h0,
        TPM_LBL_DATA = 2'h1,
        TPM_LBL_STAT = 2'h2,
        TPM_LBL_XBIT = 2'h3
    } tpm_lbl_e;
    // One pattern resource's programmed values and care masks
    typedef struct packed {
        logic not_eq_sel;
        logic [23:0] addr_val;
        logic [23:0] addr_msk;
        logic [15:0] data_val;
        logic [15:0] data_msk;
        logic [7:0] stat_val;
        logic [7:0] stat_msk;
        tpm_qual_e stat_qual;
        logic [15:0] xbit_val;
        logic [15:0] xbit_msk;
        logic [47:0] user_val;
        logic [47:0] user_msk;
    } tpm_pat_s;
    // Range resource
    typedef struct packed {
        tpm_lbl_e label;
        logic [23:0] lo_bound;
        logic [23:0] hi_bound;
    } tpm_rng_s;
endpackage : tpm_pkg
